// ===== program_memory_crc_debug.sv
// program memory crc engine with debug register port and shared pin handling
`timescale 1ns/10ps
// How it works
// R01: write to byte one starts 32-bit crc
// R02: full crc starts at address zero
// R03: 32-bit result spread over four byte registers
// R04: halted state stalls peripherals and program
// R05: halted state hands both pins to debug
// R06: user input stays steady while halted
// R07: reset and debug clock pin input only
// R08: write to byte zero starts block crc
// R09: results hold until next start, reset zero
module program_memory_crc_debug #(
    parameter int mem_bytes = crc_debug_pkg::mem_bytes_default
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // debug clock, arrives on the shared reset pin
    input wire logic debug_clock_pin,
    // halt request from device control, core domain
    input wire logic halt_req,
    output logic core_stall,
    output logic clock_pin_is_debug,
    // debug register request, link domain
    input wire logic link_req_valid,
    input wire crc_debug_pkg::link_req_s link_req,
    output logic link_busy,
    output logic link_resp_valid,
    output logic [7:0] link_resp_data,
    // debug protocol engine data drive, link domain
    input wire logic link_data_out,
    input wire logic link_data_oe,
    output logic link_data_in,
    // user function on the shared data pin, core domain
    input wire logic user_data_out,
    input wire logic user_data_oe,
    output logic user_data_in,
    // shared data pin
    input wire logic debug_data_pin_in,
    output logic debug_data_pin_out,
    output logic debug_data_pin_oe,
    // program memory read port, one cycle latency
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // engine state
    output logic crc_busy
);
    // ========================================
    // one byte through a crc register, msb first
    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] d,
                                             input logic wide);
        logic [31:0] c;
        logic fb;
        c = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (wide)
            begin
                fb = c[31] ^ d[i];
                c = {c[30:0], 1'b0} ^ (fb ? crc_debug_pkg::crc32_poly : 32'h0000_0000);
            end
            else
            begin
                fb = c[15] ^ d[i];
                c[15:0] = {c[14:0], 1'b0} ^ (fb ? crc_debug_pkg::crc16_poly : 16'h0000);
                c[31:16] = 16'h0000;
            end
        end
        return c;
    endfunction

    // ========================================
    // link side request hold and handshake
    crc_debug_pkg::link_req_s req_hold; // stays put while the toggle crosses
    logic req_tgl; // flips once per request
    logic ack_s1, ack_s2, ack_s3; // core ack toggle into link domain
    logic ack_tgl; // answer toggle back to link
    logic [7:0] resp_word; // core read data, loaded on the same core edge the ack flips

    // accept a request only when idle; extra requests while busy are dropped
    always_ff @(posedge debug_clock_pin or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_hold <= '0;
            req_tgl <= 1'b0;
            link_busy <= 1'b0;
        end
        else if (link_req_valid && !link_busy)
        begin
            req_hold <= link_req;
            req_tgl <= ~req_tgl;
            link_busy <= 1'b1;
        end
        else if (ack_s2 ^ ack_s3)
        begin
            link_busy <= 1'b0;
        end
    end

    // ack synchroniser and answer pulse
    always_ff @(posedge debug_clock_pin or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
            link_resp_valid <= 1'b0;
            link_resp_data <= 8'h00;
        end
        else
        begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
            link_resp_valid <= ack_s2 ^ ack_s3;
            if (ack_s2 ^ ack_s3)
            begin
                link_resp_data <= resp_word; // safe: word has held since the ack flipped
            end
        end
    end

    // ========================================
    // core side request detect
    logic req_s1, req_s2, req_s3; // request toggle into core domain
    logic req_seen; // one core cycle per link request

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end
        else
        begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end
    assign req_seen = req_s2 ^ req_s3;

    // ========================================
    // result registers and crc engine
    logic [7:0] crc_byte [4]; // byte zero is the lsb
    crc_debug_pkg::crc_state_e state;
    logic [31:0] crc_acc; // running crc
    logic full_mode; // high for whole-memory 32-bit run
    logic [15:0] bytes_left; // bytes still to fetch after the current one
    logic start_full, start_block;

    // starts only from idle so a running result is never disturbed
    assign start_full = req_seen && req_hold.write && state == crc_debug_pkg::st_idle &&
                        req_hold.addr == crc_debug_pkg::addr_crc_byte_one; // [R01]
    assign start_block = req_seen && req_hold.write && state == crc_debug_pkg::st_idle &&
                         req_hold.addr == crc_debug_pkg::addr_crc_byte_zero; // [R08]

    // engine sequence: fetch a byte, fold it in, repeat, then publish
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= crc_debug_pkg::st_idle;
            crc_acc <= 32'h0000_0000;
            full_mode <= 1'b0;
            bytes_left <= 16'h0000;
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
        end
        else
        begin
            mem_rd <= 1'b0;
            case (state)
                crc_debug_pkg::st_idle:
                begin
                    if (start_full)
                    begin
                        full_mode <= 1'b1;
                        crc_acc <= crc_debug_pkg::crc32_init;
                        mem_addr <= crc_debug_pkg::full_start_addr; // [R02]
                        bytes_left <= 16'(mem_bytes - 1); // [R02]
                        mem_rd <= 1'b1;
                        state <= crc_debug_pkg::st_fetch;
                    end
                    else if (start_block)
                    begin
                        full_mode <= 1'b0;
                        crc_acc <= {16'h0000, crc_debug_pkg::crc16_init};
                        mem_addr <= {req_hold.data, crc_debug_pkg::block_low_addr}; // [R08]
                        bytes_left <= 16'(crc_debug_pkg::block_bytes - 1); // [R08]
                        mem_rd <= 1'b1;
                        state <= crc_debug_pkg::st_fetch;
                    end
                end
                crc_debug_pkg::st_fetch:
                begin
                    state <= crc_debug_pkg::st_accum; // read data arrives next edge
                end
                crc_debug_pkg::st_accum:
                begin
                    crc_acc <= crc_step(crc_acc, mem_rdata, full_mode);
                    if (bytes_left == 16'h0000)
                    begin
                        state <= crc_debug_pkg::st_done;
                    end
                    else
                    begin
                        bytes_left <= bytes_left - 16'h0001;
                        mem_addr <= mem_addr + 16'h0001;
                        mem_rd <= 1'b1;
                        state <= crc_debug_pkg::st_fetch;
                    end
                end
                crc_debug_pkg::st_done:
                begin
                    state <= crc_debug_pkg::st_idle;
                end
                default:
                begin
                    state <= crc_debug_pkg::st_idle;
                end
            endcase
        end
    end

    // result bytes change only on completion or a plain store
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
            begin
                crc_byte[i] <= crc_debug_pkg::crc_byte_reset; // [R09]
            end
        end
        else if (state == crc_debug_pkg::st_done)
        begin
            crc_byte[0] <= crc_acc[7:0]; // [R03]
            crc_byte[1] <= crc_acc[15:8]; // [R03]
            if (full_mode)
            begin
                crc_byte[2] <= crc_acc[23:16]; // [R03]
                crc_byte[3] <= crc_acc[31:24]; // [R03]
            end
        end
        else if (req_seen && req_hold.write && state == crc_debug_pkg::st_idle)
        begin
            // byte zero and one writes are start commands, their values are not kept
            if (req_hold.addr == crc_debug_pkg::addr_crc_byte_two)
            begin
                crc_byte[2] <= req_hold.data;
            end
            if (req_hold.addr == crc_debug_pkg::addr_crc_byte_three)
            begin
                crc_byte[3] <= req_hold.data;
            end
        end
    end

    // read answer and ack; busy engine still answers with the last results
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resp_word <= 8'h00;
            ack_tgl <= 1'b0;
        end
        else if (req_seen)
        begin
            ack_tgl <= ~ack_tgl;
            case (req_hold.addr)
                crc_debug_pkg::addr_crc_byte_zero: resp_word <= crc_byte[0]; // [R09]
                crc_debug_pkg::addr_crc_byte_one: resp_word <= crc_byte[1]; // [R09]
                crc_debug_pkg::addr_crc_byte_two: resp_word <= crc_byte[2]; // [R09]
                crc_debug_pkg::addr_crc_byte_three: resp_word <= crc_byte[3]; // [R09]
                default: resp_word <= crc_debug_pkg::unmapped_read;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crc_busy <= 1'b0;
        end
        else
        begin
            crc_busy <= start_full || start_block ||
                        (state != crc_debug_pkg::st_idle && state != crc_debug_pkg::st_done);
        end
    end

    // ========================================
    // halt and pin sharing
    logic halt_l1, halt_l2; // halt into link domain
    logic pin_c1, pin_c2; // data pin into core domain
    logic pin_l1; // data pin into link domain
    logic user_q_out, user_q_oe; // registered user drive
    logic link_q_out, link_q_oe; // registered debug drive

    // stall everything and lend the clock pin while halted
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_stall <= 1'b0;
            clock_pin_is_debug <= 1'b0;
            user_q_out <= 1'b0;
            user_q_oe <= 1'b0;
        end
        else
        begin
            core_stall <= halt_req; // [R04]
            clock_pin_is_debug <= halt_req; // [R05]
            user_q_out <= user_data_out;
            user_q_oe <= user_data_oe && !halt_req; // [R05]
        end
    end

    // user view of the pin freezes while halted; the last two pin samples taken under debug ownership still reach it after release
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_c1 <= 1'b0;
            pin_c2 <= 1'b0;
            user_data_in <= 1'b0;
        end
        else
        begin
            pin_c1 <= debug_data_pin_in;
            pin_c2 <= pin_c1;
            if (!core_stall)
            begin
                user_data_in <= pin_c2; // [R06]
            end
        end
    end

    // debug drive only counts while the halt has reached the link domain
    always_ff @(posedge debug_clock_pin or negedge rst_n)
    begin
        if (!rst_n)
        begin
            halt_l1 <= 1'b0;
            halt_l2 <= 1'b0;
            pin_l1 <= 1'b0;
            link_data_in <= 1'b0;
            link_q_out <= 1'b0;
            link_q_oe <= 1'b0;
        end
        else
        begin
            halt_l1 <= halt_req;
            halt_l2 <= halt_l1;
            pin_l1 <= debug_data_pin_in;
            link_data_in <= pin_l1;
            link_q_out <= link_data_out;
            link_q_oe <= link_data_oe && halt_l2; // [R05]
        end
    end

    // owner select on registered drives; the debug clock may be stopped outside frames
    assign debug_data_pin_out = clock_pin_is_debug ? link_q_out : user_q_out; // [R05]
    assign debug_data_pin_oe = clock_pin_is_debug ? link_q_oe : user_q_oe; // [R05]
    // the clock pin is only ever an input here; nothing drives it back [R07]
endmodule

// ===== crc_debug_pkg.sv
// shared constants and types for the program memory crc debug block
package crc_debug_pkg;
    // ========================================
    // debug register addresses
    localparam logic [7:0] addr_crc_byte_zero = 8'ha9;
    localparam logic [7:0] addr_crc_byte_one = 8'haa;
    localparam logic [7:0] addr_crc_byte_two = 8'hab;
    localparam logic [7:0] addr_crc_byte_three = 8'hac;
    localparam logic [7:0] crc_byte_reset = 8'h00;
    localparam logic [7:0] unmapped_read = 8'h00;
    // ========================================
    // crc engine setup
    localparam int mem_bytes_default = 8192;
    localparam int block_bytes = 256;
    localparam logic [15:0] full_start_addr = 16'h0000;
    localparam logic [7:0] block_low_addr = 8'h00;
    localparam logic [31:0] crc32_poly = 32'h04c1_1db7;
    localparam logic [31:0] crc32_init = 32'hffff_ffff;
    localparam logic [15:0] crc16_poly = 16'h1021;
    localparam logic [15:0] crc16_init = 16'hffff;
    // ========================================
    // types
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } link_req_s;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_fetch = 2'b01,
        st_accum = 2'b11,
        st_done = 2'b10
    } crc_state_e;
endpackage

// ===== program_memory_crc_debug_assertions.sv
// concurrent checks on the crc debug block ports
`timescale 1ns/10ps
module program_memory_crc_debug_assertions #(
    parameter int mem_bytes = crc_debug_pkg::mem_bytes_default
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic debug_clock_pin,
    input wire logic rst_n,
    // halt and pin sharing
    input wire logic halt_req,
    input wire logic core_stall,
    input wire logic clock_pin_is_debug,
    input wire logic user_data_in,
    // link answer
    input wire logic link_busy,
    input wire logic link_resp_valid,
    input wire logic [7:0] link_resp_data,
    // memory sweep
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic crc_busy
);
    // ========================================
    // reads counted in the current run
    int rd_cnt;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_cnt <= 0;
        else if (!crc_busy)
            rd_cnt <= 0;
        else if (mem_rd)
            rd_cnt <= rd_cnt + 1;
    end
    // ========================================
    // halt and pins
    property p_stall;
        @(posedge core_clk) disable iff (!rst_n) core_stall == $past(halt_req);
    endproperty
    a_stall: assert property (p_stall) else $error("stall off halt");
    property p_owner;
        @(posedge core_clk) disable iff (!rst_n) clock_pin_is_debug == core_stall;
    endproperty
    a_owner: assert property (p_owner) else $error("pin owner wrong");
    property p_frozen;
        @(posedge core_clk) disable iff (!rst_n)
            core_stall && $past(core_stall) |-> $stable(user_data_in);
    endproperty
    a_frozen: assert property (p_frozen) else $error("user input moved");
    // ========================================
    // memory sweep
    property p_start;
        @(posedge core_clk) disable iff (!rst_n)
            $rose(crc_busy) |-> ##[0:4] (mem_rd && mem_addr[7:0] == 8'h00);
    endproperty
    a_start: assert property (p_start) else $error("bad start address");
    property p_step;
        @(posedge core_clk) disable iff (!rst_n)
            mem_rd && $past(mem_rd, 2) |-> mem_addr == $past(mem_addr, 2) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("address skipped");
    property p_count;
        @(posedge core_clk) disable iff (!rst_n)
            $fell(crc_busy) |-> (rd_cnt == mem_bytes || rd_cnt == 256);
    endproperty
    a_count: assert property (p_count) else $error("wrong byte count");
    // ========================================
    // link answers
    property p_hold;
        @(posedge debug_clock_pin) disable iff (!rst_n)
            !link_resp_valid |-> $stable(link_resp_data);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_answer;
        @(posedge debug_clock_pin) disable iff (!rst_n)
            $rose(link_busy) |-> ##[1:200] link_resp_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    // main scenarios reached
    c_halt: cover property (@(posedge core_clk) $rose(core_stall));
    c_run: cover property (@(posedge core_clk) $fell(crc_busy));
    c_resp: cover property (@(posedge debug_clock_pin) link_resp_valid);
endmodule
bind program_memory_crc_debug program_memory_crc_debug_assertions #(
    .mem_bytes(mem_bytes)
) i_program_memory_crc_debug_assertions (
    .core_clk(core_clk), .debug_clock_pin(debug_clock_pin), .rst_n(rst_n),
    .halt_req(halt_req), .core_stall(core_stall), .clock_pin_is_debug(clock_pin_is_debug),
    .user_data_in(user_data_in), .link_busy(link_busy), .link_resp_valid(link_resp_valid),
    .link_resp_data(link_resp_data), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .crc_busy(crc_busy)
);

// ===== crc_mem_model.sv
// program memory model answering reads one cycle after the request
`timescale 1ns/10ps
module crc_mem_model (
    // core clock
    input wire logic core_clk,
    // read port
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    // ========================================
    // data tied to the address so a wrong address shows in the crc;
    // between reads the bus flips so a late sample is caught
    always_ff @(posedge core_clk)
    begin
        mem_rdata <= mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5a) : ~mem_rdata;
    end
endmodule

// ===== tb_program_memory_crc_debug.sv
// self-checking bench for the program memory crc debug block
`timescale 1ns/10ps
module tb_program_memory_crc_debug;
    // ========================================
    // signals
    localparam int mem_n = 16; // short sweep keeps the run brief
    logic core_clk, rst_n, debug_clock_pin, halt_req, core_stall, clock_pin_is_debug;
    logic link_req_valid, link_busy, link_resp_valid, link_data_out, link_data_oe;
    logic link_data_in, user_data_out, user_data_oe, user_data_in, debug_data_pin_in;
    logic debug_data_pin_out, debug_data_pin_oe, mem_rd, crc_busy, ext_lvl, link_run;
    logic [7:0] link_resp_data, mem_rdata, q;
    logic [15:0] mem_addr;
    logic [31:0] exp32, exp16;
    crc_debug_pkg::link_req_s link_req;
    int error_cnt, n_tests;
    // undriven pin sits at the outside level
    assign debug_data_pin_in = debug_data_pin_oe ? debug_data_pin_out : ext_lvl;
    program_memory_crc_debug #(.mem_bytes(mem_n)) i_program_memory_crc_debug (
        .core_clk(core_clk), .rst_n(rst_n), .debug_clock_pin(debug_clock_pin),
        .halt_req(halt_req), .core_stall(core_stall), .clock_pin_is_debug(clock_pin_is_debug),
        .link_req_valid(link_req_valid), .link_req(link_req), .link_busy(link_busy),
        .link_resp_valid(link_resp_valid), .link_resp_data(link_resp_data),
        .link_data_out(link_data_out), .link_data_oe(link_data_oe), .link_data_in(link_data_in),
        .user_data_out(user_data_out), .user_data_oe(user_data_oe), .user_data_in(user_data_in),
        .debug_data_pin_in(debug_data_pin_in), .debug_data_pin_out(debug_data_pin_out),
        .debug_data_pin_oe(debug_data_pin_oe), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .crc_busy(crc_busy)
    );
    crc_mem_model i_crc_mem_model (
        .core_clk(core_clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata)
    );
    // ========================================
    // clocks; the link clock is only an input to the device
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        debug_clock_pin = 1'b0;
        #1.7;
        // the link clock stands still low between frames
        forever #3 debug_clock_pin = link_run & ~debug_clock_pin;
    end
    // ========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one request strobe, then a bounded wait for its answer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge debug_clock_pin) #1;
        link_req_valid = 1'b1;
        link_req = '{write: w, addr: a, data: d};
        @(posedge debug_clock_pin) #1;
        link_req_valid = 1'b0;
        while (link_resp_valid !== 1'b1 && n < 300)
        begin
            @(posedge debug_clock_pin) #1;
            n++;
        end
        if (n == 300)
            error_cnt++;
        q = link_resp_data;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        xfer(1'b0, a, 8'h00);
        chk(nm, q, e);
    endtask
    // engine starts on the core edge the ack flips, ahead of the answer; settle first, then poll
    task automatic wait_idle();
        int n;
        n = 0;
        // one more link edge retires the answer pulse, then the link clock stops
        @(posedge debug_clock_pin) #1;
        link_run = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        while (crc_busy !== 1'b0 && n < 1000)
        begin
            @(posedge core_clk) #1;
            n++;
        end
        if (n == 1000)
            error_cnt++;
        link_run = 1'b1;
    endtask
    // msb-first crc of the model's address pattern
    function automatic logic [31:0] crc(int w, int base, int n);
        logic [31:0] c;
        logic [15:0] a;
        c = (w == 32) ? crc_debug_pkg::crc32_init : {16'h0000, crc_debug_pkg::crc16_init};
        for (int i = 0; i < n; i++)
        begin
            a = 16'(base + i);
            c ^= {24'h00_0000, a[7:0] ^ a[15:8] ^ 8'h5a} << (w - 8);
            for (int b = 0; b < 8; b++)
                if (w == 32)
                    c = c[31] ? ((c << 1) ^ crc_debug_pkg::crc32_poly) : (c << 1);
                else
                    c = {16'h0000, c[15] ? ((c[15:0] << 1) ^ crc_debug_pkg::crc16_poly)
                                         : (c[15:0] << 1)};
        end
        return c;
    endfunction
    // ========================================
    // watchdog, far beyond the roughly 65 us of tests
    initial
    begin
        #500000;
        error_cnt++;
        stop_test();
    end
    // ========================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        halt_req = 1'b0;
        link_req_valid = 1'b0;
        link_req = '0;
        link_data_out = 1'b0;
        link_data_oe = 1'b0;
        user_data_out = 1'b0;
        user_data_oe = 1'b0;
        ext_lvl = 1'b1;
        link_run = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        repeat (6) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        // cleared after reset; unmapped place reads zero
        for (int a = 8'ha9; a <= 8'hac; a++)
            rd(a[7:0], 8'h00, "reset byte");
        rd(8'h55, 8'h00, "unmapped");
        xfer(1'b1, 8'hab, 8'h3c);
        xfer(1'b1, 8'hac, 8'hc3);
        rd(8'hab, 8'h3c, "byte two rw");
        rd(8'hac, 8'hc3, "byte three rw");
        // full sweep from zero; a write during the run is dropped
        exp32 = crc(32, 0, mem_n);
        xfer(1'b1, 8'haa, 8'h5a);
        xfer(1'b1, 8'hab, 8'h77);
        wait_idle();
        for (int i = 0; i < 4; i++)
            rd(8'ha9 + i[7:0], exp32[8*i +: 8], "crc32 byte");
        // block crc of page one leaves the upper bytes alone
        exp16 = crc(16, 32'h0000_0100, 256);
        xfer(1'b1, 8'ha9, 8'h01);
        wait_idle();
        rd(8'ha9, exp16[7:0], "crc16 lsb");
        rd(8'haa, exp16[15:8], "crc16 msb");
        rd(8'hac, exp32[31:24], "byte three kept");
        // halt: outside level stays put throughout
        @(posedge core_clk) #1;
        halt_req = 1'b1;
        user_data_oe = 1'b1;
        user_data_out = 1'b1;
        repeat (3) @(posedge core_clk);
        @(posedge debug_clock_pin) #1;
        link_data_oe = 1'b1;
        chk("stall", core_stall, 1'b1);
        chk("pin owner", clock_pin_is_debug, 1'b1);
        repeat (3) @(posedge core_clk);
        #1;
        chk("debug drive", {debug_data_pin_oe, debug_data_pin_out}, 2'b10);
        chk("link in", link_data_in, 1'b0);
        chk("user frozen", user_data_in, 1'b1);
        @(posedge debug_clock_pin) #1;
        link_data_oe = 1'b0;
        @(posedge core_clk) #1;
        halt_req = 1'b0;
        user_data_out = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk("user back", user_data_in, 1'b0);
        // reset in mid-run drops the sweep and clears every result byte
        xfer(1'b1, 8'haa, 8'h00);
        repeat (3) @(posedge core_clk);
        #1;
        chk("busy in run", crc_busy, 1'b1);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("busy after reset", crc_busy, 1'b0);
        for (int a = 8'ha9; a <= 8'hac; a++)
            rd(a[7:0], 8'h00, "byte after reset");
        stop_test();
    end
endmodule
